// [sccr_asserts.sv]
`timescale 1ns/10ps
// ************
// Checker
// ************
module sccr_asserts (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_out,
  // Register outputs
  input wire logic [4:0] soft_freq_code_out,
  input wire logic [4:0] strap_freq_out,
  input wire sccr_pkg::sccr_mode_e modulation_mode_out,
  input wire logic spread_active_out,
  input wire logic clock_tristate_out,
  input wire logic [7:0] slot_clock_gate_out,
  input wire logic [12:0] memory_clock_gate_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in);
  logic [2:0] up_q;
  logic [2:0] scl_q;
  logic scl_fell;
  logic [28:0] regs_w;
  // SCL fell within the last three clocks
  assign scl_fell = (scl_q[0] & ~scl_in) | (scl_q[1] & ~scl_q[0]) |
    (scl_q[2] & ~scl_q[1]);
  assign regs_w = {soft_freq_code_out, modulation_mode_out,
    slot_clock_gate_out, memory_clock_gate_out};
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      up_q <= 3'h0;
      scl_q <= 3'h7;
    end else begin
      up_q <= up_q + 3'(up_q != 3'h7);
      scl_q <= {scl_q[1:0], scl_in};
    end
  end
  sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
  endsequence
  sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
  endsequence
  a_start_no_drive: assert property (s_start |-> !sda_oe_out [*8])
    else $error("SDA driven at start");
  a_stop_no_drive: assert property (s_stop |-> !sda_oe_out [*8])
    else $error("SDA driven after stop");
  a_oe_on_fall: assert property ($changed(sda_oe_out) |-> scl_fell)
    else $error("SDA drive moved off an SCL fall");
  a_write_on_ack: assert property ($changed(regs_w) |-> sda_oe_out ||
    $past(sda_oe_out) || $past(sda_oe_out, 2) || $past(sda_oe_out, 3))
    else $error("register changed outside an acknowledge");
  a_reset_value: assert property ($rose(resetn_in) |->
    regs_w == 29'h01f_ffff) else $error("bad reset value");
  a_strap_fixed: assert property (up_q == 3'h7 |->
    $stable(strap_freq_out)) else $error("strap copy changed");
  a_spread_decode: assert property (spread_active_out ==
    modulation_mode_out[2]) else $error("spread flag wrong");
  a_tristate_decode: assert property (clock_tristate_out ==
    (modulation_mode_out == sccr_pkg::SCCR_MODE_TRISTATE))
    else $error("tristate flag wrong");
endmodule : sccr_asserts

bind sccr_top sccr_asserts i_asserts (
  .clk_in, .resetn_in, .scl_in, .sda_in, .sda_oe_out,
  .soft_freq_code_out, .strap_freq_out, .modulation_mode_out,
  .spread_active_out, .clock_tristate_out, .slot_clock_gate_out,
  .memory_clock_gate_out
);

// [sccr_host_model.sv]
`timescale 1ns/10ps
// ************
// Bus host
// ************
module sccr_host_model (
  // Clock
  input wire logic clk_in,
  // Device pull-down enable
  input wire logic sda_oe_in,
  // Wire levels
  output logic scl_out,
  output logic sda_out
);
  logic sda_q = 1'b1;
  // Pull-up: wire low when either side pulls
  assign sda_out = sda_q & ~sda_oe_in;
  initial scl_out = 1'b1;
  // Four {scl, sda} steps of four clocks; wire sampled after the third
  task automatic pins(input logic [7:0] v, output logic r);
    for (int i = 3; i >= 0; i--) begin
      {scl_out, sda_q} = v[2*i+:2];
      repeat (4) @(negedge clk_in);
      if (i == 1) begin
        r = sda_out;
      end
    end
  endtask : pins
  // Nine bits, last one is the acknowledge slot
  task automatic byte_x(input logic [8:0] d, output logic [8:0] r);
    logic b;
    for (int i = 8; i >= 0; i--) begin
      pins({1'b0, d[i], 1'b1, d[i], 1'b1, d[i], 1'b0, d[i]}, b);
      r[i] = b;
    end
  endtask : byte_x
  task automatic xfer(input logic [6:0] a, input logic [7:0] c, d,
      input logic rd, output logic [7:0] q, output logic [2:0] ak);
    logic [8:0] r;
    logic x;
    pins(8'h78, x);
    byte_x({a, 2'b01}, r);
    ak[2] = ~r[0];
    byte_x({c, 1'b1}, r);
    ak[1] = ~r[0];
    if (rd) begin
      pins(8'h78, x);
      byte_x({a, 2'b11}, r);
      ak[0] = ~r[0];
      byte_x(9'h1ff, r);
    end else begin
      byte_x({d, 1'b1}, r);
      ak[0] = ~r[0];
    end
    q = r[8:1];
    pins(8'h2f, x);
  endtask : xfer
endmodule : sccr_host_model

// [sccr_map.svh]
// Behaviour
// - Byte write: start, address, write, command, data, stop; acknowledge each byte.
// - Byte read: command write, repeated start, address read, one byte, host nacks.
// - Command with top bit set is a single-byte register access.
// - Low seven command bits give the register byte offset.
// - Bytes ascend; bits within a byte travel seven down to zero.
// - Byte zero bits two to zero pick the spread modulation mode.
// - Byte one bits seven to three return power-up straps, unwritable.
// - Command with top bit clear, all-zero included, is not acknowledged; byte decode needs top bit set.
`ifndef SCCR_MAP_SVH
`define SCCR_MAP_SVH

// ****************************************
// Bus address
// ****************************************
// Arbitrary default value
`define SCCR_SLAVE_ADDR 7'h5a
`define SCCR_CMD_BYTE_BIT 7

// ****************************************
// Register offsets
// ****************************************
`define SCCR_OFS_FREQ 7'h00
`define SCCR_OFS_STRAP 7'h01
`define SCCR_OFS_SLOT 7'h02
`define SCCR_OFS_HOST 7'h03
`define SCCR_OFS_MEM_LO 7'h04
`define SCCR_OFS_MEM_HI 7'h05

// ****************************************
// Field positions
// ****************************************
`define SCCR_FREQ_CODE_MSB 7
`define SCCR_FREQ_CODE_LSB 3
`define SCCR_MODE_MSB 2
`define SCCR_MODE_LSB 0
`define SCCR_STRAP_MSB 7
`define SCCR_STRAP_LSB 3
`define SCCR_REF_GATE_BIT 1
`define SCCR_HUB_MSB 7
`define SCCR_HUB_LSB 5
`define SCCR_INTC_BIT 4
`define SCCR_HOST_MSB 1
`define SCCR_HOST_LSB 0
`define SCCR_MEM_HI_MSB 4

// ****************************************
// Reset values
// ****************************************
`define SCCR_RST_FREQ_CODE 5'h00
`define SCCR_RST_MODE 3'h0
`define SCCR_RST_STRAP 5'h00
`define SCCR_RST_GATE8 8'hff
`define SCCR_RST_GATE5 5'h1f
`define SCCR_RST_GATE3 3'h7
`define SCCR_RST_GATE2 2'h3
`define SCCR_RST_GATE1 1'h1

`endif

// [sccr_pkg.sv]
package sccr_pkg;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    SCCR_MODE_OFF,
    SCCR_MODE_TEST,
    SCCR_MODE_RSVD,
    SCCR_MODE_TRISTATE,
    SCCR_MODE_DOWN_050,
    SCCR_MODE_CTR_050,
    SCCR_MODE_CTR_025,
    SCCR_MODE_CTR_038
  } sccr_mode_e;

  typedef enum logic [2:0] {
    SCCR_PH_IDLE,
    SCCR_PH_ADDR,
    SCCR_PH_CMD,
    SCCR_PH_WDATA,
    SCCR_PH_RDATA,
    SCCR_PH_RACK,
    SCCR_PH_DONE
  } sccr_phase_e;

  typedef struct packed {
    logic strobe;
    logic [6:0] offset;
    logic [7:0] data;
  } sccr_wr_s;

endpackage : sccr_pkg

// [sccr_smbus_slave.sv]
`timescale 1ns/10ps
`include "sccr_map.svh"

module sccr_smbus_slave #(
  parameter logic [6:0] SLAVE_ADDR = `SCCR_SLAVE_ADDR
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_oe_out,
  // Register side
  output sccr_pkg::sccr_wr_s wr_out,
  output logic [6:0] rd_offset_out,
  input wire logic [7:0] rd_data_in
);

  // ****************************************
  // Line events
  // ****************************************
  logic scl_q;
  logic sda_q;
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det = scl_in & scl_q & ~sda_q & sda_in;

  sccr_pkg::sccr_phase_e phase_q;
  sccr_pkg::sccr_phase_e next_q;
  logic [3:0] bitcnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic ack_q;
  logic byte_mode_q;
  logic [6:0] offset_q;

  // ****************************************
  // Acknowledge decision
  // ****************************************
  wire addr_hit = (shift_q[7:1] == SLAVE_ADDR);
  wire in_rx = (phase_q == sccr_pkg::SCCR_PH_ADDR) |
               (phase_q == sccr_pkg::SCCR_PH_CMD) |
               (phase_q == sccr_pkg::SCCR_PH_WDATA);
  wire byte_end = scl_fall & in_rx & ~ack_q & (bitcnt_q == 4'h8);
  wire cmd_byte = shift_q[`SCCR_CMD_BYTE_BIT];
  logic give_ack;
  sccr_pkg::sccr_phase_e nxt;
  always_comb begin
    give_ack = 1'b0;
    nxt = sccr_pkg::SCCR_PH_DONE;
    case (phase_q)
      sccr_pkg::SCCR_PH_ADDR: begin
        give_ack = addr_hit & (~shift_q[0] | byte_mode_q);
        nxt = shift_q[0] ? sccr_pkg::SCCR_PH_RDATA : sccr_pkg::SCCR_PH_CMD;
      end
      sccr_pkg::SCCR_PH_CMD: begin
        give_ack = cmd_byte;
        nxt = sccr_pkg::SCCR_PH_WDATA;
      end
      sccr_pkg::SCCR_PH_WDATA: begin
        give_ack = 1'b1;
        nxt = sccr_pkg::SCCR_PH_DONE;
      end
      default: begin
        give_ack = 1'b0;
        nxt = sccr_pkg::SCCR_PH_DONE;
      end
    endcase
  end

  wire wr_fire = byte_end & (phase_q == sccr_pkg::SCCR_PH_WDATA);
  wire cmd_fire = byte_end & (phase_q == sccr_pkg::SCCR_PH_CMD);

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      phase_q <= sccr_pkg::SCCR_PH_IDLE;
      next_q <= sccr_pkg::SCCR_PH_IDLE;
      bitcnt_q <= 4'h0;
      shift_q <= 8'h00;
      tx_q <= 8'h00;
      ack_q <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (start_det) begin
        phase_q <= sccr_pkg::SCCR_PH_ADDR;
        bitcnt_q <= 4'h0;
        ack_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (stop_det) begin
        phase_q <= sccr_pkg::SCCR_PH_IDLE;
        ack_q <= 1'b0;
        sda_oe_out <= 1'b0;
      end else if (scl_rise) begin
        if (in_rx & ~ack_q & (bitcnt_q < 4'h8)) begin
          shift_q <= {shift_q[6:0], sda_in};
          bitcnt_q <= bitcnt_q + 4'h1;
        end else if (phase_q == sccr_pkg::SCCR_PH_RDATA) begin
          tx_q <= {tx_q[6:0], 1'b0};
          bitcnt_q <= bitcnt_q + 4'h1;
        end else if (phase_q == sccr_pkg::SCCR_PH_RACK) begin
          phase_q <= sccr_pkg::SCCR_PH_DONE;
        end
      end else if (scl_fall) begin
        if (byte_end) begin
          if (give_ack) begin
            ack_q <= 1'b1;
            sda_oe_out <= 1'b1;
            next_q <= nxt;
          end else begin
            phase_q <= sccr_pkg::SCCR_PH_DONE;
          end
        end else if (ack_q) begin
          ack_q <= 1'b0;
          bitcnt_q <= 4'h0;
          phase_q <= next_q;
          tx_q <= rd_data_in;
          sda_oe_out <= (next_q == sccr_pkg::SCCR_PH_RDATA) & ~rd_data_in[7];
        end else if (phase_q == sccr_pkg::SCCR_PH_RDATA) begin
          if (bitcnt_q == 4'h8) begin
            sda_oe_out <= 1'b0;
            phase_q <= sccr_pkg::SCCR_PH_RACK;
          end else begin
            sda_oe_out <= ~tx_q[7];
          end
        end
      end
    end
  end

  // ****************************************
  // Command and write capture
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_mode_q <= 1'b0;
      offset_q <= 7'h00;
      wr_out <= '0;
    end else begin
      wr_out.strobe <= wr_fire;
      if (wr_fire) begin
        wr_out.offset <= offset_q;
        wr_out.data <= shift_q;
      end
      if (stop_det) begin
        byte_mode_q <= 1'b0;
      end else if (cmd_fire) begin
        byte_mode_q <= cmd_byte;
        offset_q <= shift_q[6:0];
      end
    end
  end

  assign rd_offset_out = offset_q;

endmodule : sccr_smbus_slave

// [sccr_top.sv]
`timescale 1ns/10ps
`include "sccr_map.svh"

module sccr_top #(
  parameter logic [6:0] SLAVE_ADDR = `SCCR_SLAVE_ADDR
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Frequency strap pins
  input wire logic [4:0] strap_freq_in,
  // Bus pins, open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // Frequency and modulation
  output logic [4:0] soft_freq_code_out,
  output logic [4:0] strap_freq_out,
  output sccr_pkg::sccr_mode_e modulation_mode_out,
  output logic spread_active_out,
  output logic clock_tristate_out,
  output logic test_mode_out,
  // Output gates
  output logic double_drive_reference_gate_out,
  output logic [7:0] slot_clock_gate_out,
  output logic [2:0] hub_clock_gate_out,
  output logic interrupt_ctrl_clock_gate_out,
  output logic [1:0] host_clock_gate_out,
  output logic [12:0] memory_clock_gate_out
);

  // ****************************************
  // Reset release
  // ****************************************
  logic [1:0] rst_sync_q;
  wire rst_n = rst_sync_q[1];
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end

  // ****************************************
  // Offset match
  // ****************************************
  function automatic logic ofs_hit(input logic [6:0] ofs,
                                   input logic [6:0] target);
    ofs_hit = (ofs == target);
  endfunction : ofs_hit

  // ****************************************
  // Bus slave
  // ****************************************
  sccr_pkg::sccr_wr_s wr;
  logic [6:0] rd_offset;
  logic [7:0] rd_data;

  sccr_smbus_slave #(
    .SLAVE_ADDR(SLAVE_ADDR)
  ) u_slave (
    .clk_in(clk_in),
    .rst_n_in(rst_n),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_oe_out(sda_oe_out),
    .wr_out(wr),
    .rd_offset_out(rd_offset),
    .rd_data_in(rd_data)
  );

  assign sda_out = 1'b0;

  // ****************************************
  // Write decode
  // ****************************************
  wire wr_freq = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_FREQ);
  wire wr_strap = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_STRAP);
  wire wr_slot = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_SLOT);
  wire wr_host = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_HOST);
  wire wr_mem_lo = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_MEM_LO);
  wire wr_mem_hi = wr.strobe & ofs_hit(wr.offset, `SCCR_OFS_MEM_HI);

  // ****************************************
  // Registers
  // ****************************************
  logic [4:0] freq_code_q;
  logic [2:0] mode_q;
  logic [4:0] strap_q;
  logic strap_taken_q;
  logic ref_gate_q;
  logic [7:0] slot_gate_q;
  logic [2:0] hub_gate_q;
  logic intc_gate_q;
  logic [1:0] host_gate_q;
  logic [12:0] mem_gate_q;

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      freq_code_q <= `SCCR_RST_FREQ_CODE;
      mode_q <= `SCCR_RST_MODE;
    end else if (wr_freq) begin
      freq_code_q <= wr.data[`SCCR_FREQ_CODE_MSB:`SCCR_FREQ_CODE_LSB];
      mode_q <= wr.data[`SCCR_MODE_MSB:`SCCR_MODE_LSB];
    end
  end

  // Straps caught once, first cycle after release
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= `SCCR_RST_STRAP;
      strap_taken_q <= 1'b0;
    end else if (!strap_taken_q) begin
      strap_q <= strap_freq_in;
      strap_taken_q <= 1'b1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_gate_q <= `SCCR_RST_GATE1;
    end else if (wr_strap) begin
      ref_gate_q <= wr.data[`SCCR_REF_GATE_BIT];
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      slot_gate_q <= `SCCR_RST_GATE8;
    end else if (wr_slot) begin
      slot_gate_q <= wr.data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      hub_gate_q <= `SCCR_RST_GATE3;
      intc_gate_q <= `SCCR_RST_GATE1;
      host_gate_q <= `SCCR_RST_GATE2;
    end else if (wr_host) begin
      hub_gate_q <= wr.data[`SCCR_HUB_MSB:`SCCR_HUB_LSB];
      intc_gate_q <= wr.data[`SCCR_INTC_BIT];
      host_gate_q <= wr.data[`SCCR_HOST_MSB:`SCCR_HOST_LSB];
    end
  end

  // Low and high memory gate bytes share one vector
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      mem_gate_q <= {`SCCR_RST_GATE5, `SCCR_RST_GATE8};
    end else begin
      if (wr_mem_lo) begin
        mem_gate_q[7:0] <= wr.data;
      end
      if (wr_mem_hi) begin
        mem_gate_q[12:8] <= wr.data[`SCCR_MEM_HI_MSB:0];
      end
    end
  end

  // ****************************************
  // Read mux, reserved bits read zero
  // ****************************************
  wire [7:0] rd_freq = {freq_code_q, mode_q};
  wire [7:0] rd_strap = {strap_q, 1'b0, ref_gate_q, 1'b0};
  wire [7:0] rd_host = {hub_gate_q, intc_gate_q, 2'b00, host_gate_q};
  wire [7:0] rd_mem_hi = {3'b000, mem_gate_q[12:8]};

  assign rd_data =
    ofs_hit(rd_offset, `SCCR_OFS_FREQ) ? rd_freq :
    ofs_hit(rd_offset, `SCCR_OFS_STRAP) ? rd_strap :
    ofs_hit(rd_offset, `SCCR_OFS_SLOT) ? slot_gate_q :
    ofs_hit(rd_offset, `SCCR_OFS_HOST) ? rd_host :
    ofs_hit(rd_offset, `SCCR_OFS_MEM_LO) ? mem_gate_q[7:0] :
    ofs_hit(rd_offset, `SCCR_OFS_MEM_HI) ? rd_mem_hi : 8'h00;

  // ****************************************
  // Mode decode
  // ****************************************
  wire sccr_pkg::sccr_mode_e mode_e = sccr_pkg::sccr_mode_e'(mode_q);
  wire spread_on = (mode_e == sccr_pkg::SCCR_MODE_DOWN_050) |
                   (mode_e == sccr_pkg::SCCR_MODE_CTR_050) |
                   (mode_e == sccr_pkg::SCCR_MODE_CTR_025) |
                   (mode_e == sccr_pkg::SCCR_MODE_CTR_038);

  // ****************************************
  // Outputs
  // ****************************************
  assign soft_freq_code_out = freq_code_q;
  assign strap_freq_out = strap_q;
  assign modulation_mode_out = mode_e;
  assign spread_active_out = spread_on;
  assign clock_tristate_out = (mode_e == sccr_pkg::SCCR_MODE_TRISTATE);
  assign test_mode_out = (mode_e == sccr_pkg::SCCR_MODE_TEST);
  assign double_drive_reference_gate_out = ref_gate_q;
  assign slot_clock_gate_out = slot_gate_q;
  assign hub_clock_gate_out = hub_gate_q;
  assign interrupt_ctrl_clock_gate_out = intc_gate_q;
  assign host_clock_gate_out = host_gate_q;
  assign memory_clock_gate_out = mem_gate_q;

endmodule : sccr_top

// [tb_top.sv]
`timescale 1ns/10ps
// ************
// Testbench
// ************
module tb_top;
  localparam logic [6:0] ADDR = 7'h5a;
  localparam logic [4:0] STRAPS = 5'h16;
  logic clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic [4:0] strap_freq_in = STRAPS;
  logic scl_in, sda_in, sda_oe_out, sda_out;
  logic [4:0] soft_freq_code_out, strap_freq_out;
  sccr_pkg::sccr_mode_e modulation_mode_out;
  logic spread_active_out, clock_tristate_out, test_mode_out;
  logic double_drive_reference_gate_out, interrupt_ctrl_clock_gate_out;
  logic [7:0] slot_clock_gate_out;
  logic [2:0] hub_clock_gate_out;
  logic [1:0] host_clock_gate_out;
  logic [12:0] memory_clock_gate_out;
  logic [7:0] ex [6];
  logic [7:0] q;
  logic [2:0] ak;
  int num_errors = 0;
  int check_count = 0;
  always #2.5 clk_in = ~clk_in;
  sccr_top #(.SLAVE_ADDR(ADDR)) i_dut (
    .clk_in, .resetn_in, .strap_freq_in, .scl_in, .sda_in, .sda_out,
    .sda_oe_out, .soft_freq_code_out, .strap_freq_out,
    .modulation_mode_out, .spread_active_out, .clock_tristate_out,
    .test_mode_out, .double_drive_reference_gate_out,
    .slot_clock_gate_out, .hub_clock_gate_out,
    .interrupt_ctrl_clock_gate_out, .host_clock_gate_out,
    .memory_clock_gate_out
  );
  sccr_host_model i_host (
    .clk_in, .sda_oe_in(sda_oe_out), .scl_out(scl_in), .sda_out(sda_in)
  );
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h, want %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic wreg(input logic [6:0] ofs, input logic [7:0] d);
    i_host.xfer(ADDR, {1'b1, ofs}, d, 1'b0, q, ak);
    chk(ak, 3'h7);
  endtask : wreg
  task automatic rreg(input logic [6:0] ofs, input logic [7:0] exp);
    i_host.xfer(ADDR, {1'b1, ofs}, 8'h00, 1'b1, q, ak);
    chk(ak, 3'h7);
    chk(q, exp);
  endtask : rreg
  task automatic rd_all();
    for (int i = 0; i < 6; i++) begin
      rreg(7'(i), ex[i]);
    end
  endtask : rd_all
  task automatic outs();
    logic [2:0] m;
    logic [2:0] f;
    logic [7:0] g;
    m = ex[0][2:0];
    f = {m[2], m == 3'h3, m == 3'h1};
    g = {hub_clock_gate_out, interrupt_ctrl_clock_gate_out, 2'b00,
      host_clock_gate_out};
    chk({soft_freq_code_out, modulation_mode_out}, ex[0]);
    chk({spread_active_out, clock_tristate_out, test_mode_out}, f);
    chk(strap_freq_out, ex[1][7:3]);
    chk(double_drive_reference_gate_out, ex[1][1]);
    chk(slot_clock_gate_out, ex[2]);
    chk(g, ex[3]);
    chk(memory_clock_gate_out, {ex[5][4:0], ex[4]});
    chk(sda_out, 1'b0);
  endtask : outs
  task automatic rst();
    resetn_in = 1'b0;
    repeat (3) @(negedge clk_in);
    resetn_in = 1'b1;
    repeat (6) @(negedge clk_in);
    ex = '{8'h00, {strap_freq_in, 3'h2}, 8'hff, 8'hf3, 8'hff, 8'h1f};
  endtask : rst
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    rst();
    outs();
    rd_all();
    $display("test reset values done");
    for (int m = 0; m < 8; m++) begin
      ex[0] = {5'h15 ^ 5'(m), 3'(m)};
      wreg(7'h00, ex[0]);
      outs();
    end
    rreg(7'h00, ex[0]);
    $display("test modulation modes done");
    // Straps move after capture; the copy must not follow
    strap_freq_in = 5'h09;
    ex[1] = {STRAPS, 3'h0};
    ex[2] = 8'h5a;
    ex[3] = 8'h52;
    ex[4] = 8'h3c;
    ex[5] = 8'h0a;
    wreg(7'h01, 8'hf8);
    for (int i = 2; i < 6; i++) begin
      wreg(7'(i), ex[i]);
    end
    outs();
    rd_all();
    $display("test gates and straps done");
    i_host.xfer(ADDR, 8'h02, 8'h00, 1'b0, q, ak);
    chk(ak[2:1], 2'h2);
    i_host.xfer(ADDR, 8'h00, 8'h00, 1'b0, q, ak);
    chk(ak[2:1], 2'h2);
    i_host.xfer(ADDR ^ 7'h01, 8'h82, 8'h00, 1'b0, q, ak);
    chk(ak[2], 1'b0);
    wreg(7'h06, 8'h00);
    outs();
    rreg(7'h06, 8'h00);
    $display("test refusals done");
    rst();
    outs();
    $display("test second reset done");
    tally_and_finish();
  end
  // Hang guard
  initial begin
    repeat (100000) @(posedge clk_in);
    num_errors++;
    tally_and_finish();
  end
endmodule : tb_top
